// File: common/i2sfp_defines.vh
`ifndef I2SFP_DEFINES_VH
`define I2SFP_DEFINES_VH
`define I2SFP_OFF_DATA    4'h0
`define I2SFP_OFF_CFG     4'h4
`define I2SFP_OFF_ENA     4'h8
`define I2SFP_FIFO_DEPTH  4'hc
`define I2SFP_BURST       4'h4
`define I2SFP_BIT_TXU     25
`define I2SFP_BIT_TXO     24
`define I2SFP_BIT_RXU     23
`define I2SFP_BIT_RXO     22
`define I2SFP_BIT_TXBURST 21
`define I2SFP_BIT_TXEMPTY 20
`define I2SFP_BIT_TXFULL  19
`define I2SFP_BIT_RXBURST 18
`define I2SFP_BIT_RXEMPTY 17
`define I2SFP_BIT_RXFULL  16
`define I2SFP_BIT_FIRST   9
`define I2SFP_BIT_TXEN    6
`define I2SFP_BIT_RXEN    5
`define I2SFP_FMT_I2S     2'h0
`define I2SFP_FMT_LEFT    2'h1
`define I2SFP_FMT_RIGHT   2'h2
`define I2SFP_RST_WIDTH   5'h12
`define I2SFP_RST_TXEN    1'h0
`define I2SFP_RST_RXEN    1'h1
`define I2SFP_RST_ENA     1'h0
`endif

// File: src/i2sfp_sample_fifo_port.v
// Functional notes
// [RL1] Decode data, config/status, enable words
// [RL2] Data write pushes tx, read pops rx
// [RL3] Both FIFOs hold twelve samples
// [RL4] Software moves samples in channel pairs
// [RL5] Sample in bits 23:0, upper zero
// [RL6] Software writes zero to reserved bits
// [RL7] Software aligns samples of other widths
// [RL8] Sticky tx underflow bit 25, read clears
// [RL9] Sticky tx overflow bit 24, read clears
// [RL10] Sticky rx underflow bit 23, read clears
// [RL11] Sticky rx overflow bit 22, read clears
// [RL12] Sticky flags also take written values
// [RL13] Bit 21: tx room for four
// [RL14] Bits 20/19: tx empty, tx full
// [RL15] Bit 18: rx holds four or more
// [RL16] Bits 17/16: rx empty, rx full
// [RL17] Software checks status before data access
// [RL18] Enable register turns port on/off
// [RL19] Format field selects I2S/left/right framing
// [RL20] Bit 9 picks first channel
// [RL21] Width field bits 4:0, reset 10010
// [RL22] Tx enable resets 0, rx resets 1
// [RL23] Full write dropped, empty read flagged
`timescale 1ns/1ps
`include "i2sfp_defines.vh"
module i2sfp_sample_fifo_port (
  input  wire        clk,
  input  wire        rst,
  input  wire [3:0]  busAddr,
  input  wire [31:0] busWdata,
  input  wire        busWrite,
  input  wire        busRead,
  output reg  [31:0] busRdata,
  input  wire        serialBitClock,
  input  wire        wordSelectClock,
  input  wire        serialDataIn,
  output reg         serialDataOut,
  output wire        portEnable
);
  localparam ST_WAIT  = 3'b001;
  localparam ST_SHIFT = 3'b010;
  localparam ST_IDLE  = 3'b100;

  reg  [23:0] txMem [0:11];
  reg  [23:0] rxMem [0:11];
  reg  [3:0]  txWr_q, txRd_q, txCnt_q, rxWr_q, rxRd_q, rxCnt_q;
  reg         txU_q, txO_q, rxU_q, rxO_q;
  reg  [1:0]  fmt_q;
  reg         first_q, txEn_q, rxEn_q, portEn_q;
  reg  [4:0]  width_q;
  reg  [6:0]  cfgMisc_q;
  reg  [2:0]  bclkSync_q, wsSync_q;
  reg  [1:0]  dinSync_q;
  reg  [2:0]  state_q;
  reg  [23:0] txShift_q, rxShift_q;
  reg  [4:0]  bitCnt_q;
  reg         delay_q, rxDone_q;

  wire hitData = (busAddr == `I2SFP_OFF_DATA);
  wire hitCfg  = (busAddr == `I2SFP_OFF_CFG);
  wire hitEna  = (busAddr == `I2SFP_OFF_ENA);
  wire txFull  = (txCnt_q == `I2SFP_FIFO_DEPTH);
  wire txEmpty = (txCnt_q == 4'h0);
  wire rxFull  = (rxCnt_q == `I2SFP_FIFO_DEPTH);
  wire rxEmpty = (rxCnt_q == 4'h0);
  wire txBurst = ((`I2SFP_FIFO_DEPTH - txCnt_q) >= `I2SFP_BURST); // [RL13]
  wire rxBurst = (rxCnt_q >= `I2SFP_BURST); // [RL15]
  wire busPush = busWrite && hitData && !txFull; // [RL23]
  wire busPop  = busRead && hitData && !rxEmpty;

  // Link edges from synchronised samples; only stages 1 and 2 feed logic
  wire bclkRise = bclkSync_q[1] && !bclkSync_q[2];
  wire bclkFall = !bclkSync_q[1] && bclkSync_q[2];
  wire wsNow    = wsSync_q[1];
  wire wsEdge   = wsSync_q[1] != wsSync_q[2];
  wire dinNow   = dinSync_q[1];
  wire leftLevel = (fmt_q == `I2SFP_FMT_I2S) ? 1'b0 : 1'b1; // [RL19]
  wire firstLevel = first_q ? !leftLevel : leftLevel; // [RL20]
  wire lsbFirst = (fmt_q == `I2SFP_FMT_RIGHT);
  wire [4:0] lastBit = width_q - 5'h1;
  wire active = portEn_q; // [RL18]

  wire i2sFmt = (fmt_q == `I2SFP_FMT_I2S);
  wire wsStart = wsEdge && (wsNow == firstLevel);
  wire txLateStart = delay_q && (bitCnt_q == 5'h0);
  // First bit leaves on the word-clock edge itself, or one bit clock later in I2S framing
  wire txLoad = bclkFall && (((state_q == ST_WAIT) && wsStart && !i2sFmt) ||
                ((state_q == ST_SHIFT) && (wsEdge ? !i2sFmt : txLateStart)));
  wire txPop  = active && txEn_q && txLoad;
  wire [23:0] txWord = txEmpty ? 24'h0 : txMem[txRd_q];
  // Last received bit lands in the shifter on this edge, so the store waits one cycle
  wire rxLast = active && rxEn_q && (state_q == ST_SHIFT) && bclkRise && !delay_q
                && !wsEdge && (bitCnt_q == lastBit);
  wire rxPush = rxDone_q;
  wire txUnder = txPop && txEmpty;
  wire rxOver  = rxPush && rxFull;

  wire [31:0] cfgRead = {6'h0, txU_q, txO_q, rxU_q, rxO_q, txBurst, txEmpty, txFull,
                         rxBurst, rxEmpty, rxFull, 4'h0, cfgMisc_q[1:0], first_q, fmt_q,
                         txEn_q, rxEn_q, width_q}; // [RL14] [RL16]
  wire [3:0] txWrNext = (txWr_q == `I2SFP_FIFO_DEPTH - 4'h1) ? 4'h0 : txWr_q + 4'h1;
  wire [3:0] txRdNext = (txRd_q == `I2SFP_FIFO_DEPTH - 4'h1) ? 4'h0 : txRd_q + 4'h1;
  wire [3:0] rxWrNext = (rxWr_q == `I2SFP_FIFO_DEPTH - 4'h1) ? 4'h0 : rxWr_q + 4'h1;
  wire [3:0] rxRdNext = (rxRd_q == `I2SFP_FIFO_DEPTH - 4'h1) ? 4'h0 : rxRd_q + 4'h1;
  wire txPopOk  = txPop && !txEmpty;
  wire rxPushOk = rxPush && !rxFull;

  assign portEnable = portEn_q;

  always @(posedge clk) begin
    if (rst) begin
      bclkSync_q <= 3'h0;
      wsSync_q   <= 3'h0;
      dinSync_q  <= 2'h0;
    end else begin
      bclkSync_q <= {bclkSync_q[1:0], serialBitClock};
      wsSync_q   <= {wsSync_q[1:0], wordSelectClock};
      dinSync_q  <= {dinSync_q[0], serialDataIn};
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rst) begin
      busRdata <= 32'h0;
    end else if (busRead) begin
      if (hitData) begin
        busRdata <= {8'h0, rxMem[rxRd_q]}; // [RL2] [RL5]
      end else if (hitCfg) begin
        busRdata <= cfgRead;
      end else if (hitEna) begin
        busRdata <= {31'h0, portEn_q};
      end else begin
        busRdata <= 32'h0;
      end
    end else begin
      busRdata <= 32'h0;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      fmt_q     <= `I2SFP_FMT_I2S;
      first_q   <= 1'b0;
      txEn_q    <= `I2SFP_RST_TXEN; // [RL22]
      rxEn_q    <= `I2SFP_RST_RXEN;
      width_q   <= `I2SFP_RST_WIDTH; // [RL21]
      cfgMisc_q <= 7'h0;
      portEn_q  <= `I2SFP_RST_ENA;
    end else if (busWrite && hitCfg) begin // [RL1]
      fmt_q     <= busWdata[8:7];
      first_q   <= busWdata[`I2SFP_BIT_FIRST];
      txEn_q    <= busWdata[`I2SFP_BIT_TXEN];
      rxEn_q    <= busWdata[`I2SFP_BIT_RXEN];
      width_q   <= busWdata[4:0];
      cfgMisc_q <= {5'h0, busWdata[11:10]};
    end else if (busWrite && hitEna) begin
      portEn_q  <= busWdata[0]; // [RL18]
    end
  end

  // Sticky flags: hardware set wins over read-clear and over a write of zero
  always @(posedge clk) begin
    if (rst) begin
      txU_q <= 1'b0;
      txO_q <= 1'b0;
      rxU_q <= 1'b0;
      rxO_q <= 1'b0;
    end else begin
      if (busWrite && hitCfg) begin // [RL12]
        txU_q <= busWdata[`I2SFP_BIT_TXU];
        txO_q <= busWdata[`I2SFP_BIT_TXO];
        rxU_q <= busWdata[`I2SFP_BIT_RXU];
        rxO_q <= busWdata[`I2SFP_BIT_RXO];
      end else if (busRead && hitCfg) begin
        txU_q <= 1'b0;
        txO_q <= 1'b0;
        rxU_q <= 1'b0;
        rxO_q <= 1'b0;
      end
      if (txUnder) txU_q <= 1'b1; // [RL8]
      if (busWrite && hitData && txFull) txO_q <= 1'b1; // [RL9] [RL23]
      if (busRead && hitData && rxEmpty) rxU_q <= 1'b1; // [RL10] [RL23]
      if (rxOver) rxO_q <= 1'b1; // [RL11]
    end
  end

  // FIFO storage, twelve entries each, circular pointers
  always @(posedge clk) begin
    if (busPush) txMem[txWr_q] <= busWdata[23:0]; // [RL3] [RL5]
    if (rxPushOk) rxMem[rxWr_q] <= rxShift_q;
  end

  always @(posedge clk) begin
    if (rst || !txEn_q) begin
      txWr_q  <= 4'h0;
      txRd_q  <= 4'h0;
      txCnt_q <= 4'h0;
    end else begin
      if (busPush) txWr_q <= txWrNext; // [RL2]
      if (txPopOk) txRd_q <= txRdNext;
      if (busPush && !txPopOk) txCnt_q <= txCnt_q + 4'h1;
      else if (!busPush && txPopOk) txCnt_q <= txCnt_q - 4'h1;
    end
  end

  always @(posedge clk) begin
    if (rst || !rxEn_q) begin
      rxWr_q  <= 4'h0;
      rxRd_q  <= 4'h0;
      rxCnt_q <= 4'h0;
    end else begin
      if (rxPushOk) rxWr_q <= rxWrNext;
      if (busPop) rxRd_q <= rxRdNext; // [RL2]
      if (rxPushOk && !busPop) rxCnt_q <= rxCnt_q + 4'h1;
      else if (!rxPushOk && busPop) rxCnt_q <= rxCnt_q - 4'h1;
    end
  end

  // Serializer: device is bit-clock slave, drives on falling, samples on rising edge
  always @(posedge clk) begin
    if (rst || !active) begin
      state_q   <= ST_IDLE;
      rxShift_q <= 24'h0;
      bitCnt_q  <= 5'h0;
      delay_q   <= 1'b0;
      rxDone_q  <= 1'b0;
    end else begin
      rxDone_q <= rxLast;
      case (state_q)
        ST_IDLE: begin
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          // Hold off until word clock changes to the first channel's level
          if (wsStart) begin // [RL20]
            state_q  <= ST_SHIFT;
            bitCnt_q <= 5'h0;
            delay_q  <= i2sFmt; // [RL19]
          end
        end
        ST_SHIFT: begin
          if (wsEdge) begin
            bitCnt_q <= 5'h0;
            delay_q  <= i2sFmt;
          end else if (bclkFall) begin
            delay_q <= 1'b0;
          end else if (bclkRise && !delay_q && (bitCnt_q <= lastBit)) begin
            if (lsbFirst) rxShift_q[bitCnt_q] <= dinNow;
            else rxShift_q[lastBit - bitCnt_q] <= dinNow;
            bitCnt_q <= bitCnt_q + 5'h1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Transmit shifter; bit slots past the sample width go out as zero
  always @(posedge clk) begin
    if (rst || !active) begin
      txShift_q     <= 24'h0;
      serialDataOut <= 1'b0;
    end else if (txLoad) begin // [RL19]
      txShift_q     <= txWord;
      serialDataOut <= lsbFirst ? txWord[0] : txWord[lastBit];
    end else if (bclkFall && (state_q == ST_SHIFT) && !wsEdge) begin
      if ((bitCnt_q != 5'h0) && (bitCnt_q <= lastBit)) begin
        serialDataOut <= lsbFirst ? txShift_q[bitCnt_q] : txShift_q[lastBit - bitCnt_q];
      end else begin
        serialDataOut <= 1'b0;
      end
    end
  end
endmodule // i2sfp_sample_fifo_port

// File: verif/i2sfp_props.sv
`timescale 1ns/1ps
module i2sfp_props (
  input wire        clk,
  input wire        rst,
  input wire [3:0]  busAddr,
  input wire [31:0] busWdata,
  input wire        busWrite,
  input wire        busRead,
  input wire [31:0] busRdata,
  input wire        serialBitClock,
  input wire        wordSelectClock,
  input wire        serialDataIn,
  input wire        serialDataOut,
  input wire        portEnable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  rdata_idle_a: assert property (!$past(busRead) |-> busRdata == 32'h0)
    else $error("read data not zero outside an answer");
  unmapped_zero_a: assert property ($past(busRead) && $past(busAddr) != 4'h0
    && $past(busAddr) != 4'h4 && $past(busAddr) != 4'h8 |-> busRdata == 32'h0)
    else $error("unmapped read not zero");
  data_upper_a: assert property ($past(busRead) && $past(busAddr) == 4'h0
    |-> busRdata[31:24] == 8'h0)
    else $error("data port upper byte not zero");
  cfg_reserved_a: assert property ($past(busRead) && $past(busAddr) == 4'h4
    |-> busRdata[31:26] == 6'h0 && busRdata[15:12] == 4'h0)
    else $error("status reserved bits not zero");
  enable_write_a: assert property (busWrite && busAddr == 4'h8
    |=> portEnable == $past(busWdata[0]))
    else $error("port enable did not follow write");
  enable_hold_a: assert property (!(busWrite && busAddr == 4'h8) |=> $stable(portEnable))
    else $error("port enable changed without write");
  sticky_clear_a: assert property (busRead && busAddr == 4'h4 && !portEnable
    ##1 busRead && busAddr == 4'h4 && !portEnable |=> busRdata[25:22] == 4'h0)
    else $error("sticky flags survived a status read");
  tx_level_a: assert property ($past(busRead) && $past(busAddr) == 4'h4
    |-> (busRdata[19] ? !busRdata[21] && !busRdata[20] : 1'b1) && (!busRdata[20] || busRdata[21]))
    else $error("tx level flags inconsistent");
  rx_level_a: assert property ($past(busRead) && $past(busAddr) == 4'h4
    |-> (busRdata[16] ? busRdata[18] && !busRdata[17] : 1'b1) && (!busRdata[17] || !busRdata[18]))
    else $error("rx level flags inconsistent");
endmodule // i2sfp_props

// File: verif/i2sfp_codec_model.sv
`timescale 1ns/1ps
module i2sfp_codec_model (
  input  wire run,
  input  wire serialDataOut,
  output reg  serialBitClock,
  output reg  wordSelectClock,
  output reg  serialDataIn
);
  integer bitCnt;
  // Bit clock stands still while not running; data changes on the falling edge
  initial begin
    serialBitClock = 1'b0;
    wordSelectClock = 1'b0;
    serialDataIn = 1'b0;
    bitCnt = 0;
    #137;
    forever begin
      #400;
      if (run) begin
        serialBitClock = ~serialBitClock;
        if (!serialBitClock) begin
          bitCnt = bitCnt + 1;
          serialDataIn = bitCnt[1] ^ bitCnt[3];
          if (bitCnt % 24 == 0) wordSelectClock = ~wordSelectClock;
        end
      end
    end
  end
endmodule // i2sfp_codec_model

// File: verif/tb_i2sfp_sample_fifo_port.sv
`timescale 1ns/1ps
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_i2sfp_sample_fifo_port;
  reg          clk = 1'b0;
  reg          rst = 1'b1;
  reg          busWrite = 1'b0;
  reg          busRead = 1'b0;
  reg          run = 1'b0;
  reg          rdSeen = 1'b0;
  reg  [3:0]   busAddr = 4'h0;
  reg  [31:0]  busWdata = 32'h0;
  reg  [31:0]  st;
  wire [31:0]  busRdata;
  wire         sBck, wClk, sIn, sOut, portEnable;
  reg          wsLast = 1'b0;
  reg          txArm = 1'b0;
  reg  [17:0]  txCap = 18'h0;
  reg  [31:0]  w;
  wire [17:0]  txGot = {txCap[16:0], sOut};
  logic [17:0] txQ[$];
  logic [17:0] txExp;
  int          txBit = 0;
  logic [63:0] expQ[$];
  logic [63:0] ent;
  int          errors = 0;
  int          samplesChecked = 0;
  int          i;
  always #50 clk = ~clk;
  i2sfp_sample_fifo_port i2sfp_sample_fifo_port_inst (.clk(clk), .rst(rst), .busAddr(busAddr),
    .busWdata(busWdata), .busWrite(busWrite), .busRead(busRead), .busRdata(busRdata),
    .serialBitClock(sBck), .wordSelectClock(wClk), .serialDataIn(sIn),
    .serialDataOut(sOut), .portEnable(portEnable));
  i2sfp_codec_model i2sfp_codec_model_inst (.run(run), .serialDataOut(sOut),
    .serialBitClock(sBck), .wordSelectClock(wClk), .serialDataIn(sIn));
  task wr(input [3:0] a, input [31:0] d);
    @(posedge clk);
    busWrite <= 1'b1;
    busRead <= 1'b0;
    busAddr <= a;
    busWdata <= d;
  endtask
  task rd(input [3:0] a, input [31:0] m, input [31:0] e);
    @(posedge clk);
    busRead <= 1'b1;
    busWrite <= 1'b0;
    busAddr <= a;
    expQ.push_back({m, e});
  endtask
  task idle(input int n);
    repeat (n) begin
      @(posedge clk);
      busRead <= 1'b0;
      busWrite <= 1'b0;
    end
  endtask
  task final_report;
    $display("checks %0d errors %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) rdSeen <= busRead;
  // Answer stands only in the cycle after the strobe, so look mid-cycle
  always @(negedge clk) begin
    if (rdSeen && expQ.size() > 0) begin
      ent = expQ.pop_front();
      `CHK(busRdata & ent[63:32], ent[31:0])
    end
  end
  // Serial out taken at codec rising edges: I2S, 18-bit, MSB one bit after word clock
  always @(posedge sBck) begin
    wsLast <= wClk;
    if (wClk != wsLast) begin
      txBit <= 0;
      if (!wClk) txArm <= 1'b1;
    end else begin
      if (txBit < 31) txBit <= txBit + 1;
      if (txBit < 18) txCap <= txGot;
      if (txArm && txBit == 17 && txQ.size() > 0) begin
        txExp = txQ.pop_front();
        `CHK(txGot, txExp)
      end
    end
  end
  initial begin
    #2000000;
    errors++;
    final_report;
  end
  initial begin
    void'($urandom(32'h599491e0));
    idle(5);
    rst <= 1'b0;
    rd(4'h4, 32'hffffffff, 32'h00320032);
    rd(4'h8, 32'h00000001, 32'h0);
    rd(4'hc, 32'hffffffff, 32'h0);
    for (i = 0; i < 6; i++) begin
      st = {22'h0, i[0], i[2:1], 2'b01, i[0] ? 5'h10 : 5'h08};
      wr(4'h4, st);
      rd(4'h4, 32'h000003ff, st);
    end
    wr(4'h4, 32'h00000072);
    for (i = 1; i <= 13; i++) begin
      w = $urandom & 32'h00ffffff;
      if (i <= 12) txQ.push_back(w[17:0]);
      wr(4'h0, w);
      rd(4'h4, 32'h03ff0000, {7'h0, i == 13, 2'b0, i <= 8, 1'b0, i >= 12, 3'b010, 16'h0});
    end
    rd(4'h4, 32'h01000000, 32'h0);
    rd(4'h0, 32'hff000000, 32'h0);
    rd(4'h4, 32'h00800000, 32'h00800000);
    rd(4'h4, 32'h00820000, 32'h00020000);
    wr(4'h4, 32'h03c00072);
    rd(4'h4, 32'h03c00000, 32'h03c00000);
    rd(4'h4, 32'h03c00000, 32'h0);
    wr(4'h8, 32'h00000001);
    run <= 1'b1;
    idle(6000);
    rd(4'h8, 32'h00000001, 32'h00000001);
    rd(4'h4, 32'h03ff0000, 32'h02750000);
    wr(4'h8, 32'h0);
    run <= 1'b0;
    idle(4);
    for (i = 0; i < 12; i++) rd(4'h0, 32'hff000000, 32'h0);
    rd(4'h4, 32'h00870000, 32'h00020000);
    idle(3);
    final_report;
  end
endmodule // tb_i2sfp_sample_fifo_port
bind i2sfp_sample_fifo_port i2sfp_props i2sfp_props_inst (.clk(clk), .rst(rst),
  .busAddr(busAddr), .busWdata(busWdata), .busWrite(busWrite), .busRead(busRead),
  .busRdata(busRdata), .serialBitClock(serialBitClock), .wordSelectClock(wordSelectClock),
  .serialDataIn(serialDataIn), .serialDataOut(serialDataOut), .portEnable(portEnable));
